// [shared/aer_pkg.sv]
//----------------------------------------------------------------------------
// Behaviour
// - Header word at 0x100 is read-only, resets to 0x0001_0001, ID 0x0001.
// - Header bits 19:16 return the read-only capability version 1.
// - Header bits 31:20 hold the next pointer 0x000, which ends the list.
// - Status at 0x104 resets to 0; flags 20..16 set on detect, clear on 1.
// - Status bits 15, 14, 13 and 12 are write-one-to-clear error flags.
// - Status bit 4 is a write-one-to-clear flag; other low bits read 0.
// - Mask at 0x108 has the same bits, read-write, sticky, resets to 0.
// - Severity at 0x10C resets to 0x0006_2030, same per-error bits.
//----------------------------------------------------------------------------
package aer_pkg;

  localparam logic [11:0] AER_OFF_HEADER   = 12'h100;
  localparam logic [11:0] AER_OFF_STATUS   = 12'h104;
  localparam logic [11:0] AER_OFF_MASK     = 12'h108;
  localparam logic [11:0] AER_OFF_SEVERITY = 12'h10c;

  localparam logic [15:0] AER_CAP_IDENT    = 16'h0001;
  localparam logic [3:0]  AER_CAP_VERSION  = 4'h1;
  localparam logic [11:0] AER_NEXT_CAP     = 12'h000;
  localparam logic [31:0] AER_HEADER_RESET = 32'h0001_0001;

  localparam logic [31:0] AER_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] AER_MASK_RESET   = 32'h0000_0000;
  localparam logic [31:0] AER_SEV_RESET    = 32'h0006_2030;
  // Implemented error classes: bits 20..12 and 4
  localparam logic [31:0] AER_ERR_BITS     = 32'h001f_f010;

  localparam int AER_BIT_UNSUP    = 20;
  localparam int AER_BIT_CRC      = 19;
  localparam int AER_BIT_MALFORM  = 18;
  localparam int AER_BIT_OVERFLOW = 17;
  localparam int AER_BIT_UNEXPCPL = 16;
  localparam int AER_BIT_CMPABORT = 15;
  localparam int AER_BIT_CPLTMO   = 14;
  localparam int AER_BIT_FLOWCTL  = 13;
  localparam int AER_BIT_POISON   = 12;
  localparam int AER_BIT_DLLPROT  = 4;
  localparam int AER_NUM_CLASSES  = 10;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } aer_cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic        hit;
    logic [31:0] rdata;
  } aer_cfg_rsp_t;

endpackage

// [design/aer_flag.sv]
`timescale 1ns/10ps
module aer_flag (
  input  wire logic CLK,
  input  wire logic PWR_RST,
  input  wire logic SET,
  input  wire logic CLR,
  output logic      Q
);
  logic q_reg;
  logic q_next;

  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    q_next = q_reg;
    if (CLR) begin
      q_next = 1'b0;
    end
    if (SET) begin
      q_next = 1'b1;
    end
  end

  // Sticky: only power-on reset or a CLR clears
  always_ff @(posedge CLK) begin
    if (PWR_RST) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign Q = q_reg;

endmodule

// [design/aer_regs.sv]
`timescale 1ns/10ps
module aer_regs (
  input  wire logic                  CLK,
  input  wire logic                  SRST,
  input  wire logic                  PWR_RST,
  input  wire aer_pkg::aer_cfg_req_t CFG_REQ,
  output aer_pkg::aer_cfg_rsp_t      CFG_RSP,
  input  wire logic [31:0]           ERR_DETECT,
  output logic [31:0]                ERR_REPORT,
  output logic [31:0]                ERR_FATAL
);
  import aer_pkg::*;

  //--------------------------------------------------------------------------
  // Byte-enable write data
  //--------------------------------------------------------------------------
  logic [31:0] be_mask;
  logic        wr_status;
  logic        wr_mask;
  logic        wr_sev;
  logic [31:0] status_q;
  logic [31:0] clr_vec;
  logic [31:0] header;

  always_comb begin
    be_mask = {{8{CFG_REQ.be[3]}}, {8{CFG_REQ.be[2]}},
               {8{CFG_REQ.be[1]}}, {8{CFG_REQ.be[0]}}};
  end

  assign wr_status = CFG_REQ.wr && (CFG_REQ.addr == AER_OFF_STATUS);
  assign wr_mask   = CFG_REQ.wr && (CFG_REQ.addr == AER_OFF_MASK);
  assign wr_sev    = CFG_REQ.wr && (CFG_REQ.addr == AER_OFF_SEVERITY);
  assign clr_vec   = wr_status ? (CFG_REQ.wdata & be_mask) : 32'h0000_0000;

  assign header = {AER_NEXT_CAP, AER_CAP_VERSION, AER_CAP_IDENT};

  //--------------------------------------------------------------------------
  // Status flags
  //--------------------------------------------------------------------------
  // Only implemented classes get a flop; other bits tie to zero
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_flag
      if (AER_ERR_BITS[gi]) begin : g_impl
        aer_flag u_flag (
          .CLK     (CLK),
          .PWR_RST (PWR_RST),
          .SET     (ERR_DETECT[gi]),
          .CLR     (clr_vec[gi]),
          .Q       (status_q[gi])
        );
      end else begin : g_zero
        assign status_q[gi] = 1'b0;
      end
    end
  endgenerate

  //--------------------------------------------------------------------------
  // Mask and severity
  //--------------------------------------------------------------------------
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic [31:0] sev_reg;
  logic [31:0] sev_next;

  always_comb begin
    mask_next = mask_reg;
    sev_next  = sev_reg;
    if (wr_mask) begin
      mask_next = ((CFG_REQ.wdata & be_mask) | (mask_reg & ~be_mask))
                  & AER_ERR_BITS;
    end
    // Bits outside the error classes keep their reset value
    if (wr_sev) begin
      sev_next = (((CFG_REQ.wdata & be_mask) | (sev_reg & ~be_mask))
                  & AER_ERR_BITS) | (sev_reg & ~AER_ERR_BITS);
    end
  end

  // Sticky registers ignore the ordinary reset
  always_ff @(posedge CLK) begin
    if (PWR_RST) begin
      mask_reg <= AER_MASK_RESET;
      sev_reg  <= AER_SEV_RESET;
    end else begin
      mask_reg <= mask_next;
      sev_reg  <= sev_next;
    end
  end

  // Masked classes keep their flag but are not reported
  assign ERR_REPORT = status_q & ~mask_reg;
  assign ERR_FATAL  = ERR_REPORT & sev_reg;

  //--------------------------------------------------------------------------
  // Read response
  //--------------------------------------------------------------------------
  aer_cfg_rsp_t rsp_reg;
  aer_cfg_rsp_t rsp_next;

  always_comb begin
    rsp_next       = '0;
    rsp_next.ack   = CFG_REQ.rd || CFG_REQ.wr;
    rsp_next.hit   = 1'b1;
    if (CFG_REQ.rd) begin
      case (CFG_REQ.addr)
        AER_OFF_HEADER:   rsp_next.rdata = header;
        AER_OFF_STATUS:   rsp_next.rdata = status_q;
        AER_OFF_MASK:     rsp_next.rdata = mask_reg;
        AER_OFF_SEVERITY: rsp_next.rdata = sev_reg;
        default: begin
          rsp_next.rdata = 32'h0000_0000;
          rsp_next.hit   = 1'b0;
        end
      endcase
    end else begin
      rsp_next.hit = wr_status || wr_mask || wr_sev ||
                     (CFG_REQ.addr == AER_OFF_HEADER);
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign CFG_RSP = rsp_reg;

  //--------------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------------
  chk_header_value: assert property (@(posedge CLK) disable iff (SRST)
    CFG_REQ.rd && CFG_REQ.addr == AER_OFF_HEADER |=>
      CFG_RSP.rdata == AER_HEADER_RESET)
    else $error("header read wrong");
  chk_version_field: assert property (@(posedge CLK) disable iff (SRST)
    CFG_REQ.rd && CFG_REQ.addr == AER_OFF_HEADER |=>
      CFG_RSP.rdata[19:16] == 4'h1)
    else $error("version field wrong");
  chk_next_pointer: assert property (@(posedge CLK) disable iff (SRST)
    CFG_REQ.rd && CFG_REQ.addr == AER_OFF_HEADER |=>
      CFG_RSP.rdata[31:20] == 12'h000)
    else $error("next pointer wrong");
  chk_flag_sets: assert property (@(posedge CLK) disable iff (PWR_RST)
    ERR_DETECT[AER_BIT_UNSUP] |=> status_q[AER_BIT_UNSUP])
    else $error("flag not set on detect");
  chk_clear_one: assert property (@(posedge CLK) disable iff (PWR_RST)
    clr_vec[AER_BIT_CMPABORT] && !ERR_DETECT[AER_BIT_CMPABORT] |=>
      !status_q[AER_BIT_CMPABORT])
    else $error("write one did not clear");
  chk_reserved_zero: assert property (
    @(posedge CLK) disable iff (PWR_RST)
    (status_q & ~AER_ERR_BITS) == 32'h0 &&
    (mask_reg & ~AER_ERR_BITS) == 32'h0)
    else $error("reserved bit set");
  chk_sev_fixed: assert property (@(posedge CLK) disable iff (PWR_RST)
    (sev_reg & ~AER_ERR_BITS) == (AER_SEV_RESET & ~AER_ERR_BITS))
    else $error("severity fixed bit changed");
  chk_mask_write: assert property (@(posedge CLK) disable iff (PWR_RST)
    wr_mask && CFG_REQ.be == 4'hf |=>
      mask_reg == ($past(CFG_REQ.wdata) & AER_ERR_BITS))
    else $error("mask write lost");
  chk_sev_reset: assert property (@(posedge CLK)
    PWR_RST |=> sev_reg == AER_SEV_RESET)
    else $error("severity reset wrong");
  chk_mask_hides: assert property (@(posedge CLK) disable iff (PWR_RST)
    mask_reg[AER_BIT_DLLPROT] |-> !ERR_REPORT[AER_BIT_DLLPROT])
    else $error("masked error reported");
  chk_sticky_srst: assert property (@(posedge CLK) disable iff (PWR_RST)
    SRST && !wr_mask |=> mask_reg == $past(mask_reg))
    else $error("mask lost on reset");

endmodule

// [verification/aer_host.sv]
`timescale 1ns/10ps
module aer_host (
  input  wire logic                  CLK,
  output aer_pkg::aer_cfg_req_t      REQ,
  input  wire aer_pkg::aer_cfg_rsp_t RSP
);
  import aer_pkg::*;
  initial REQ = '0;
  // One word per access; after release the lines show the inverse, not the
  // last value, so a design that samples late is caught
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output aer_cfg_rsp_t r);
    @(negedge CLK);
    REQ = '{rd: !w, wr: w, addr: a, wdata: d, be: be};
    @(negedge CLK);
    REQ = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d, be: ~be};
    r = RSP;
  endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import aer_pkg::*;
  logic         clk, srst, pwr_rst;
  aer_cfg_req_t req;
  aer_cfg_rsp_t rsp;
  aer_cfg_rsp_t rsp_sc;
  logic [31:0]  det, rep, fat, st_m, mk_m, sev_m;
  int           error_cnt, samples_checked;
  aer_host host (.CLK(clk), .REQ(req), .RSP(rsp));
  aer_regs DUT (.CLK(clk), .SRST(srst), .PWR_RST(pwr_rst), .CFG_REQ(req),
    .CFG_RSP(rsp), .ERR_DETECT(det), .ERR_REPORT(rep), .ERR_FATAL(fat));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] bm(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic h);
    aer_cfg_rsp_t r;
    host.xfer(1'b0, a, 32'h0, 4'hf, r);
    chk({r.ack, r.hit}, {1'b1, h});
    chk(r.rdata, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] be, input logic h);
    aer_cfg_rsp_t r;
    logic [31:0]  m;
    m = bm(be) & AER_ERR_BITS;
    host.xfer(1'b1, a, d, be, r);
    chk({r.ack, r.hit}, {1'b1, h});
    if (a == 12'h104) st_m &= ~(d & m);
    if (a == 12'h108) mk_m = (mk_m & ~m) | (d & m);
    if (a == 12'h10c) sev_m = (sev_m & ~m) | (d & m);
  endtask
  task automatic pulse(input logic [31:0] v);
    @(negedge clk);
    det = v;
    @(negedge clk);
    det = '0;
    st_m |= v & AER_ERR_BITS;
    chk(rep, st_m & ~mk_m);
    chk(fat, st_m & ~mk_m & sev_m);
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  //--------------------------------------------------------------------
  // Main sequence
  //--------------------------------------------------------------------
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    {srst, pwr_rst, det} = {2'b11, 32'h0};
    {st_m, mk_m, sev_m} = {64'h0, AER_SEV_RESET};
    void'($urandom(11249));
    repeat (16) @(posedge clk);
    @(negedge clk);
    {srst, pwr_rst} = 2'b00;
    rd(12'h100, 32'h0001_0001, 1'b1);
    wr(12'h100, 32'hffff_ffff, 4'hf, 1'b1);
    rd(12'h100, 32'h0001_0001, 1'b1);
    rd(12'h104, 32'h0, 1'b1);
    rd(12'h108, 32'h0, 1'b1);
    rd(12'h10c, 32'h0006_2030, 1'b1);
    rd(12'h0fc, 32'h0, 1'b0);
    // Every bit position, reserved ones included, set then cleared
    for (int i = 0; i < 32; i++) begin
      pulse(32'h1 << i);
      rd(12'h104, st_m, 1'b1);
      wr(12'h104, 32'h1 << i, 4'hf, 1'b1);
      rd(12'h104, st_m, 1'b1);
    end
    repeat (6) begin
      wr(12'h108, $urandom, 4'($urandom), 1'b1);
      rd(12'h108, mk_m, 1'b1);
      wr(12'h10c, $urandom, 4'($urandom), 1'b1);
      rd(12'h10c, sev_m, 1'b1);
      pulse($urandom);
      rd(12'h104, st_m, 1'b1);
      wr(12'h104, $urandom, 4'($urandom), 1'b1);
      rd(12'h104, st_m, 1'b1);
    end
    // A clear and a detect of one flag in the same cycle: the set wins
    wr(12'h104, 32'hffff_ffff, 4'hf, 1'b1);
    fork
      host.xfer(1'b1, 12'h104, AER_ERR_BITS, 4'hf, rsp_sc);
      pulse(32'h1 << AER_BIT_POISON);
    join
    chk({rsp_sc.ack, rsp_sc.hit}, 2'b11);
    rd(12'h104, st_m, 1'b1);
    pulse(AER_ERR_BITS);
    @(negedge clk);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rd(12'h104, st_m, 1'b1);
    rd(12'h108, mk_m, 1'b1);
    pwr_rst = 1'b1;
    repeat (2) @(negedge clk);
    pwr_rst = 1'b0;
    rd(12'h104, 32'h0, 1'b1);
    rd(12'h108, 32'h0, 1'b1);
    rd(12'h10c, 32'h0006_2030, 1'b1);
    give_verdict();
  end
endmodule
